// >>> logic/bai_core.sv
// Execution datapath for an accumulator core: logic, moves, literal
// load, subtract, rotates, swap, prescaler load, return, power-down.
// Assumes a sequencer offers instruction words with valid/ready, a
// file array answering FILE_RDATA_I in the cycle FILE_ADDR_O is shown,
// and a stack presenting its top on STACK_TOP_I.
//
// Notes on behaviour
// RL1 - OR acc with file, route, update zero
// RL2 - Store acc to file, flags unchanged
// RL3 - Copy file to dest, update zero
// RL4 - Literal to acc, flags unchanged
// RL5 - Acc to prescaler config, flags unchanged
// RL6 - Return: literal to acc, pc from stack
// RL7 - Return takes two instruction cycles
// RL8 - Power-down clears watchdog and its prescaler
// RL9 - Power-down sets timeout, clears powerdown, keeps wake
// RL10 - Then enters sleep, oscillator stopped
// RL11 - Rotate left through carry, only carry
// RL12 - Rotate right through carry, only carry
// RL13 - File minus acc, updates carry, half, zero
// RL14 - Swap nibbles, route, no flag change
// RL15 - Zero flag set exactly when result zero
// RL16 - No-op only advances program counter
`timescale 1ns/1ps
`include "bai_cfg.svh"

module bai_core import bai_pkg::*; (
    input wire logic CLK_I,              // Core clock, 100 MHz
    input wire logic RST_N_I,            // Async reset, active low
    input wire logic CE_I,               // Clock enable, freezes state
    input wire logic INSTR_VALID_I,      // Instruction offered
    input wire logic [11:0] INSTR_I,     // Instruction word
    output logic INSTR_READY_O,          // Instruction taken
    output logic [4:0] FILE_ADDR_O,      // File register address
    input wire logic [7:0] FILE_RDATA_I, // File register read data
    output logic [7:0] FILE_WDATA_O,     // File register write data
    output logic FILE_WE_O,              // File write pulse
    input wire logic [9:0] STACK_TOP_I,  // Top of return stack
    output logic STACK_POP_O,            // Stack pop pulse
    output logic [9:0] PC_O,             // Program counter
    output logic PC_LOAD_O,              // Pc loaded from stack pulse
    input wire logic WDT_TICK_I,         // Watchdog clock tick
    input wire logic PIN_CHANGE_I,       // Pin change seen in sleep
    input wire logic WAKE_I,             // Wake-up event
    output logic SLEEP_O,                // Sleeping, oscillator stopped
    input wire logic [2:0] REG_ADDR_I,   // Register address
    input wire logic [7:0] REG_WDATA_I,  // Register write data
    input wire logic REG_WR_I,           // Register write strobe
    input wire logic REG_RD_I,           // Register read strobe
    output logic [7:0] REG_RDATA_O       // Read data, one cycle later
);

    bai_state_t state_reg;
    logic [11:0] instr_reg;
    logic [7:0] acc_reg;
    logic [7:0] status_reg;
    logic [7:0] presc_cfg_reg;
    logic [7:0] wdt_reg;
    logic [7:0] wdt_presc_reg;
    logic [7:0] ctrl_reg;
    logic [9:0] pc_reg;
    logic [3:0] opc;
    logic dir;
    logic exec;
    bai_fn_t fn;
    logic [7:0] alu_res;
    logic alu_c, alu_half, alu_z;
    logic wr_acc, wr_file;

    assign opc = instr_reg[`BAI_OPC_HI:`BAI_OPC_LO];
    assign dir = instr_reg[`BAI_DIR_BIT];
    assign fn = bai_fn_of(opc);
    // Execute cycle is only real when the clock is enabled
    assign exec = (state_reg == ST_EXEC) && CE_I;

    // Run bit in the control register lets software hold the core
    assign INSTR_READY_O = (state_reg == ST_IDLE) && ctrl_reg[0];
    assign PC_O = pc_reg;
    assign SLEEP_O = (state_reg == ST_SLEEP);

    bai_alu u_alu (
        .fn_i(fn),
        .acc_i(acc_reg),
        .file_i(FILE_RDATA_I),
        .carry_i(status_reg[`BAI_ST_C]),
        .result_o(alu_res),
        .carry_o(alu_c),
        .half_o(alu_half),
        .zero_o(alu_z)
    );

    // Destination routing by the direction bit
    always_comb begin
        wr_acc = 1'b0;
        wr_file = 1'b0;
        case (opc)
            `BAI_OPC_OR, `BAI_OPC_COPY, `BAI_OPC_ROTL, `BAI_OPC_ROTR,
            `BAI_OPC_SUB, `BAI_OPC_SWAP: begin
                wr_acc = !dir; // [RL1] [RL3] [RL11] [RL12] [RL13] [RL14]
                wr_file = dir;
            end
            `BAI_OPC_STORE: wr_file = 1'b1; // [RL2]
            default: begin
                wr_acc = 1'b0;
                wr_file = 1'b0;
            end
        endcase
    end

    // Sequencer: take, execute, optional return cycle, sleep
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_reg <= ST_IDLE;
            instr_reg <= 12'h000;
        end else if (CE_I) begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (INSTR_VALID_I && INSTR_READY_O) begin
                        instr_reg <= INSTR_I;
                        state_reg <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (opc == `BAI_OPC_RETLIT) begin
                        state_reg <= ST_RET2; // [RL7]
                    end else if (opc == `BAI_OPC_SLEEP) begin
                        state_reg <= ST_SLEEP; // [RL10]
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_RET2: state_reg <= ST_IDLE;
                ST_SLEEP: begin
                    if (WAKE_I) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // File address shown from the take onward
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            FILE_ADDR_O <= 5'h00;
        end else if (CE_I && state_reg == ST_IDLE && INSTR_VALID_I &&
                     INSTR_READY_O) begin
            FILE_ADDR_O <= INSTR_I[`BAI_FADDR_HI:`BAI_FADDR_LO];
        end
    end

    // File write pulse after the execute cycle
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            FILE_WE_O <= 1'b0;
            FILE_WDATA_O <= 8'h00;
        end else if (CE_I) begin
            FILE_WE_O <= exec && wr_file;
            if (exec && wr_file) begin
                // Store writes the accumulator, the rest the unit result
                FILE_WDATA_O <= (opc == `BAI_OPC_STORE) ?
                                acc_reg : alu_res; // [RL2] [RL3]
            end
        end
    end

    // Accumulator; an instruction write beats a software write
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            acc_reg <= `BAI_RST_ACC;
        end else if (CE_I) begin
            if (exec && wr_acc) begin
                acc_reg <= alu_res; // [RL1] [RL3] [RL13] [RL14]
            end else if (exec && (opc == `BAI_OPC_LDLIT ||
                                  opc == `BAI_OPC_RETLIT)) begin
                acc_reg <= instr_reg[`BAI_LIT_HI:`BAI_LIT_LO]; // [RL4] [RL6]
            end else if (REG_WR_I && REG_ADDR_I == `BAI_REG_ACC) begin
                acc_reg <= REG_WDATA_I;
            end
        end
    end

    // Status flags; literal, store, swap, option, return leave them
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            status_reg <= `BAI_RST_STATUS;
        end else if (CE_I) begin
            if (REG_WR_I && REG_ADDR_I == `BAI_REG_STATUS) begin
                // Software owns only the arithmetic flags and wake flag
                status_reg[`BAI_ST_C] <= REG_WDATA_I[`BAI_ST_C];
                status_reg[`BAI_ST_HALF] <= REG_WDATA_I[`BAI_ST_HALF];
                status_reg[`BAI_ST_Z] <= REG_WDATA_I[`BAI_ST_Z];
                status_reg[`BAI_ST_WAKE] <= REG_WDATA_I[`BAI_ST_WAKE];
            end
            unique case (1'b1)
                exec && (opc == `BAI_OPC_OR || opc == `BAI_OPC_COPY):
                    status_reg[`BAI_ST_Z] <= alu_z; // [RL1] [RL3] [RL15]
                exec && (opc == `BAI_OPC_ROTL || opc == `BAI_OPC_ROTR):
                    status_reg[`BAI_ST_C] <= alu_c; // [RL11] [RL12]
                exec && opc == `BAI_OPC_SUB: begin
                    status_reg[`BAI_ST_C] <= alu_c; // [RL13]
                    status_reg[`BAI_ST_HALF] <= alu_half;
                    status_reg[`BAI_ST_Z] <= alu_z;
                end
                exec && opc == `BAI_OPC_SLEEP: begin
                    status_reg[`BAI_ST_TMOUT] <= 1'b1; // [RL9]
                    status_reg[`BAI_ST_PWRDN] <= 1'b0;
                end
                default: ;
            endcase
            // Pin change in sleep sets the flag; set wins over clear
            if (state_reg == ST_SLEEP && PIN_CHANGE_I) begin
                status_reg[`BAI_ST_WAKE] <= 1'b1;
            end
        end
    end

    // Prescaler configuration register
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            presc_cfg_reg <= `BAI_RST_PRESC;
        end else if (exec && opc == `BAI_OPC_OPTION) begin
            presc_cfg_reg <= acc_reg; // [RL5]
        end
    end

    // Watchdog counter and prescaler; power-down clears both
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wdt_reg <= `BAI_WDT_CLR;
            wdt_presc_reg <= `BAI_PRESC_CLR;
        end else if (CE_I) begin
            if (exec && opc == `BAI_OPC_SLEEP) begin
                wdt_reg <= `BAI_WDT_CLR; // [RL8]
                wdt_presc_reg <= `BAI_PRESC_CLR;
            end else if (WDT_TICK_I) begin
                // Prescaler overflow carries into the counter
                wdt_presc_reg <= wdt_presc_reg + 8'h01;
                if (wdt_presc_reg == 8'hFF) begin
                    wdt_reg <= wdt_reg + 8'h01;
                end
            end
        end
    end

    // Program counter and return pulses
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pc_reg <= `BAI_RST_PC;
            STACK_POP_O <= 1'b0;
            PC_LOAD_O <= 1'b0;
        end else if (CE_I) begin
            STACK_POP_O <= exec && opc == `BAI_OPC_RETLIT; // [RL6]
            PC_LOAD_O <= (state_reg == ST_RET2);
            if (state_reg == ST_RET2) begin
                pc_reg <= STACK_TOP_I; // [RL6] [RL7]
            end else if (exec && opc != `BAI_OPC_RETLIT) begin
                pc_reg <= pc_reg + 10'h001; // [RL16]
            end
        end
    end

    // Control register: bit 0 lets instructions be taken
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl_reg <= `BAI_RST_CTRL;
        end else if (CE_I && REG_WR_I && REG_ADDR_I == `BAI_REG_CTRL) begin
            ctrl_reg <= {7'h00, REG_WDATA_I[0]};
        end
    end

    // Read data for one cycle after the strobe, zero otherwise
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            REG_RDATA_O <= 8'h00;
        end else if (CE_I) begin
            REG_RDATA_O <= 8'h00;
            if (REG_RD_I) begin
                case (REG_ADDR_I)
                    `BAI_REG_ACC: REG_RDATA_O <= acc_reg;
                    `BAI_REG_STATUS: REG_RDATA_O <= status_reg;
                    `BAI_REG_PRESC: REG_RDATA_O <= presc_cfg_reg;
                    `BAI_REG_WDT: REG_RDATA_O <= wdt_reg;
                    `BAI_REG_CTRL: REG_RDATA_O <= ctrl_reg;
                    default: REG_RDATA_O <= 8'h00;
                endcase
            end
        end
    end

    // Checks on the execute results
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    a_or_into_acc: assert property ( // [RL1]
        exec && opc == `BAI_OPC_OR && !dir |=>
        acc_reg == ($past(acc_reg) | $past(FILE_RDATA_I)))
        else $error("or result wrong");

    a_store_file: assert property ( // [RL2]
        exec && opc == `BAI_OPC_STORE |=>
        FILE_WE_O && FILE_WDATA_O == $past(acc_reg) && $stable(status_reg))
        else $error("store wrong");

    a_copy_zero: assert property ( // [RL3]
        exec && opc == `BAI_OPC_COPY |=>
        status_reg[`BAI_ST_Z] == ($past(FILE_RDATA_I) == 8'h00))
        else $error("copy zero flag wrong");

    a_literal_load: assert property ( // [RL4]
        exec && opc == `BAI_OPC_LDLIT && !REG_WR_I |=>
        acc_reg == $past(instr_reg[7:0]) && $stable(status_reg))
        else $error("literal load wrong");

    a_option_load: assert property ( // [RL5]
        exec && opc == `BAI_OPC_OPTION |=>
        presc_cfg_reg == $past(acc_reg))
        else $error("prescaler config load wrong");

    a_return_seq: assert property ( // [RL7]
        exec && opc == `BAI_OPC_RETLIT ##1 CE_I |=>
        PC_LOAD_O && pc_reg == $past(STACK_TOP_I) && INSTR_READY_O)
        else $error("return sequence wrong");

    a_return_pop: assert property ( // [RL6]
        exec && opc == `BAI_OPC_RETLIT |=> STACK_POP_O &&
        acc_reg == $past(instr_reg[7:0]) && state_reg == ST_RET2)
        else $error("return pop wrong");

    a_sleep_clear: assert property ( // [RL8]
        exec && opc == `BAI_OPC_SLEEP |=>
        wdt_reg == 8'h00 && wdt_presc_reg == 8'h00)
        else $error("watchdog not cleared");

    a_sleep_flags: assert property ( // [RL9]
        exec && opc == `BAI_OPC_SLEEP |=> status_reg[`BAI_ST_TMOUT] &&
        !status_reg[`BAI_ST_PWRDN] && SLEEP_O)
        else $error("power-down flags wrong");

    a_rotate_left: assert property ( // [RL11]
        exec && opc == `BAI_OPC_ROTL && !dir |=>
        {status_reg[`BAI_ST_C], acc_reg} ==
        {$past(FILE_RDATA_I), $past(status_reg[`BAI_ST_C])})
        else $error("rotate left wrong");

    a_sub_carry: assert property ( // [RL13]
        exec && opc == `BAI_OPC_SUB |=>
        status_reg[`BAI_ST_C] == ($past(FILE_RDATA_I) >= $past(acc_reg)))
        else $error("subtract carry wrong");

    a_nop_pc: assert property ( // [RL16]
        exec && opc == `BAI_OPC_NOP && !REG_WR_I |=>
        pc_reg == $past(pc_reg) + 10'h001 && $stable(acc_reg))
        else $error("no-op changed state");

    c_return: cover property (exec && opc == `BAI_OPC_RETLIT);
    c_sleep_wake: cover property (SLEEP_O ##1 !SLEEP_O);
    c_sub_to_file: cover property (exec && opc == `BAI_OPC_SUB && dir);

endmodule

// >>> logic/bai_cfg.svh
// Constants of the accumulator datapath: instruction fields, opcodes,
// status bit positions, register offsets and reset values.
// Assumes it is included by bare name from every design file.
`ifndef BAI_CFG_SVH
`define BAI_CFG_SVH

// Instruction word fields
`define BAI_INSTR_W 12
`define BAI_OPC_HI 11
`define BAI_OPC_LO 8
`define BAI_DIR_BIT 5
`define BAI_FADDR_HI 4
`define BAI_FADDR_LO 0
`define BAI_LIT_HI 7
`define BAI_LIT_LO 0

// Opcodes in bits 11:8
`define BAI_OPC_NOP 4'h0
`define BAI_OPC_OR 4'h1
`define BAI_OPC_STORE 4'h2
`define BAI_OPC_COPY 4'h3
`define BAI_OPC_LDLIT 4'h4
`define BAI_OPC_OPTION 4'h5
`define BAI_OPC_RETLIT 4'h6
`define BAI_OPC_SLEEP 4'h7
`define BAI_OPC_ROTL 4'h8
`define BAI_OPC_ROTR 4'h9
`define BAI_OPC_SUB 4'hA
`define BAI_OPC_SWAP 4'hB

// Status register bit positions
`define BAI_ST_C 0
`define BAI_ST_HALF 1
`define BAI_ST_Z 2
`define BAI_ST_PWRDN 3
`define BAI_ST_TMOUT 4
`define BAI_ST_WAKE 7

// Register offsets on the software port
`define BAI_REG_ACC 3'h0
`define BAI_REG_STATUS 3'h1
`define BAI_REG_PRESC 3'h2
`define BAI_REG_WDT 3'h3
`define BAI_REG_CTRL 3'h4

// Reset values
`define BAI_RST_ACC 8'h00
`define BAI_RST_STATUS 8'h18
`define BAI_RST_PRESC 8'hFF
`define BAI_RST_CTRL 8'h01
`define BAI_RST_PC 10'h000
`define BAI_WDT_CLR 8'h00
`define BAI_PRESC_CLR 8'h00

`endif

// >>> logic/bai_pkg.sv
// Types shared by the accumulator datapath and its arithmetic unit.
// Assumes bai_cfg.svh is on the include path.
`include "bai_cfg.svh"

package bai_pkg;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_RET2,
        ST_SLEEP
    } bai_state_t;

    // Arithmetic unit functions
    typedef enum logic [2:0] {
        FN_PASS_F,
        FN_OR,
        FN_SUB,
        FN_ROTL,
        FN_ROTR,
        FN_SWAP
    } bai_fn_t;

    // Opcode to arithmetic function
    function automatic bai_fn_t bai_fn_of(input logic [3:0] opc);
        bai_fn_t fn;
        fn = FN_PASS_F;
        case (opc)
            `BAI_OPC_OR: fn = FN_OR;
            `BAI_OPC_SUB: fn = FN_SUB;
            `BAI_OPC_ROTL: fn = FN_ROTL;
            `BAI_OPC_ROTR: fn = FN_ROTR;
            `BAI_OPC_SWAP: fn = FN_SWAP;
            default: fn = FN_PASS_F;
        endcase
        return fn;
    endfunction

endpackage

// >>> logic/bai_alu.sv
// Combinational arithmetic unit of the accumulator datapath.
// Assumes operands are stable for the whole execute cycle.
`timescale 1ns/1ps
`include "bai_cfg.svh"

module bai_alu import bai_pkg::*; (
    input wire bai_fn_t fn_i,        // Function select
    input wire logic [7:0] acc_i,    // Accumulator operand
    input wire logic [7:0] file_i,   // File register operand
    input wire logic carry_i,        // Carry flag in
    output logic [7:0] result_o,     // Result byte
    output logic carry_o,            // Carry out
    output logic half_o,             // Low nibble carry out
    output logic zero_o              // Result is zero
);

    // Zero test shared by all functions
    function automatic logic is_zero(input logic [7:0] v);
        return (v == 8'h00);
    endfunction

    logic [8:0] sum_full;
    logic [4:0] sum_low;

    // Subtraction as file plus inverted accumulator plus one
    assign sum_full = {1'b0, file_i} + {1'b0, ~acc_i} + 9'h001; // [RL13]
    assign sum_low = {1'b0, file_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;

    // Function mux; carry passes through where unchanged
    always_comb begin
        result_o = file_i;
        carry_o = carry_i;
        half_o = sum_low[4];
        unique case (fn_i)
            FN_PASS_F: result_o = file_i;
            FN_OR: result_o = acc_i | file_i; // [RL1]
            FN_SUB: begin
                result_o = sum_full[7:0];
                carry_o = sum_full[8]; // [RL13]
            end
            FN_ROTL: begin
                result_o = {file_i[6:0], carry_i}; // [RL11]
                carry_o = file_i[7];
            end
            FN_ROTR: begin
                result_o = {carry_i, file_i[7:1]}; // [RL12]
                carry_o = file_i[0];
            end
            FN_SWAP: result_o = {file_i[3:0], file_i[7:4]}; // [RL14]
        endcase
        zero_o = is_zero(result_o); // [RL15]
    end

endmodule

// >>> verif/bai_file_model.sv
// Far-side model: file register array and return stack.
// Assumes the core shows FILE_ADDR_O and expects data the same cycle.
`timescale 1ns/1ps

module bai_file_model #(
    parameter logic [9:0] TOP = 10'h155 // Return address, plain default
) (
    input wire logic clk_i,          // Core clock
    input wire logic [4:0] addr_i,   // File address
    input wire logic [7:0] wdata_i,  // Write data
    input wire logic we_i,           // Write pulse
    output logic [7:0] rdata_o,      // Read data
    input wire logic pop_i,          // Stack pop pulse
    output logic [9:0] top_o         // Top of stack
);
    logic [7:0] mem [32];
    logic popped;

    // Array starts cleared so copies of unused files read zero
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        popped = 1'b0;
    end

    // Same-cycle read of the addressed file
    assign rdata_o = mem[addr_i];

    // Writes land on the edge closing the pulse
    always @(posedge clk_i) begin
        if (we_i) mem[addr_i] <= wdata_i;
        if (pop_i) popped <= 1'b1;
    end

    // An emptied stack shows garbage, not the old address
    assign top_o = popped ? ~TOP : TOP;
endmodule

// >>> verif/test_bai_core.sv
// Testbench for the accumulator datapath, sequence of instructions.
// Assumes the file model answers reads in the cycle they are shown.
`timescale 1ns/1ps
`include "bai_cfg.svh"

module test_bai_core;
    import bai_pkg::*;
    logic CLK_I, RST_N_I, INSTR_VALID_I, WDT_TICK_I, WAKE_I;
    logic CE_I, PIN_CHANGE_I;
    logic REG_WR_I, REG_RD_I, INSTR_READY_O, FILE_WE_O, STACK_POP_O;
    logic PC_LOAD_O, SLEEP_O;
    logic [11:0] INSTR_I;
    logic [4:0] FILE_ADDR_O;
    logic [7:0] FILE_RDATA_I, FILE_WDATA_O, REG_WDATA_I, REG_RDATA_O;
    logic [9:0] STACK_TOP_I, PC_O;
    logic [2:0] REG_ADDR_I;
    int errors = 0;
    int checks_done = 0;
    int cyc;

    bai_core dut (.CLK_I, .RST_N_I, .CE_I, .INSTR_VALID_I, .INSTR_I,
        .INSTR_READY_O, .FILE_ADDR_O, .FILE_RDATA_I, .FILE_WDATA_O,
        .FILE_WE_O, .STACK_TOP_I, .STACK_POP_O, .PC_O, .PC_LOAD_O,
        .WDT_TICK_I, .PIN_CHANGE_I, .WAKE_I, .SLEEP_O, .REG_ADDR_I,
        .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O);

    bai_file_model mdl (.clk_i(CLK_I), .addr_i(FILE_ADDR_O),
        .wdata_i(FILE_WDATA_O), .we_i(FILE_WE_O), .rdata_o(FILE_RDATA_I),
        .pop_i(STACK_POP_O), .top_o(STACK_TOP_I));

    // Free-running core clock
    initial begin
        CLK_I = 1'b0;
        forever #5 CLK_I = ~CLK_I;
    end

    task automatic chk(input string name, input logic [9:0] seen,
                       input logic [9:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Offer one word, then count cycles until ready returns (cap 20)
    task automatic exec(input logic [11:0] w);
        int k;
        @(posedge CLK_I);
        INSTR_VALID_I <= 1'b1;
        INSTR_I <= w;
        for (k = 0; k < 20; k++) begin
            @(posedge CLK_I);
            if (INSTR_READY_O === 1'b1) break;
        end
        INSTR_VALID_I <= 1'b0;
        for (cyc = 1; cyc < 20; cyc++) begin
            @(posedge CLK_I);
            #1;
            if (INSTR_READY_O === 1'b1) break;
        end
        // One more edge lets the file write pulse land in the model
        @(posedge CLK_I);
        #1;
    endtask

    // File-operand word: opcode, direction, address
    function automatic logic [11:0] fop(logic [3:0] o, logic d, int f);
        return {o, 2'b00, d, 5'(f)};
    endfunction

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLK_I);
        REG_WR_I <= 1'b1;
        REG_ADDR_I <= a;
        REG_WDATA_I <= d;
        @(posedge CLK_I);
        REG_WR_I <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp,
                          input string name);
        @(posedge CLK_I);
        REG_RD_I <= 1'b1;
        REG_ADDR_I <= a;
        @(posedge CLK_I);
        REG_RD_I <= 1'b0;
        #1;
        chk(name, {2'b00, REG_RDATA_O}, {2'b00, exp});
    endtask

    // Tick the watchdog input for exactly n sampled edges
    task automatic ticks(input int n);
        @(posedge CLK_I);
        WDT_TICK_I <= 1'b1;
        repeat (n) @(posedge CLK_I);
        WDT_TICK_I <= 1'b0;
    endtask

    // Hang guard, far beyond the roughly one thousand cycles used
    initial begin
        #200000;
        errors++;
        stop_test();
    end

    initial begin
        {INSTR_VALID_I, WDT_TICK_I, WAKE_I, REG_WR_I, REG_RD_I} = '0;
        PIN_CHANGE_I = 1'b0;
        CE_I = 1'b1;
        INSTR_I = '0;
        REG_ADDR_I = '0;
        REG_WDATA_I = '0;
        RST_N_I = 1'b0;
        repeat (5) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        // Reset values and an unmapped offset
        reg_rd(`BAI_REG_ACC, `BAI_RST_ACC, "acc");
        reg_rd(`BAI_REG_STATUS, `BAI_RST_STATUS, "status");
        reg_rd(`BAI_REG_PRESC, `BAI_RST_PRESC, "presc");
        reg_rd(`BAI_REG_WDT, 8'h00, "wdt");
        reg_rd(3'h5, 8'h00, "unmapped");
        exec({`BAI_OPC_LDLIT, 8'h3C});
        chk("plain cycles", 10'(cyc), 10'd1);
        reg_rd(`BAI_REG_ACC, 8'h3C, "acc");
        reg_rd(`BAI_REG_STATUS, 8'h18, "status");
        exec(fop(`BAI_OPC_STORE, 1'b1, 5));
        chk("file5", mdl.mem[5], 8'h3C);
        reg_rd(`BAI_REG_STATUS, 8'h18, "status");
        mdl.mem[6] = 8'hC3;
        exec(fop(`BAI_OPC_OR, 1'b0, 6));
        reg_rd(`BAI_REG_ACC, 8'hFF, "or acc");
        reg_rd(`BAI_REG_STATUS, 8'h18, "status");
        exec(fop(`BAI_OPC_COPY, 1'b1, 7));
        reg_rd(`BAI_REG_STATUS, 8'h1C, "copy zero");
        chk("file7", mdl.mem[7], 8'h00);
        // Subtract: equal, positive and borrowing cases
        exec({`BAI_OPC_LDLIT, 8'h3C});
        exec(fop(`BAI_OPC_SUB, 1'b0, 5));
        reg_rd(`BAI_REG_ACC, 8'h00, "sub acc");
        reg_rd(`BAI_REG_STATUS, 8'h1F, "sub eq");
        exec(fop(`BAI_OPC_SUB, 1'b1, 6));
        chk("file6", mdl.mem[6], 8'hC3);
        reg_rd(`BAI_REG_STATUS, 8'h1B, "sub pos");
        exec({`BAI_OPC_LDLIT, 8'h01});
        exec(fop(`BAI_OPC_SUB, 1'b0, 7));
        reg_rd(`BAI_REG_ACC, 8'hFF, "sub acc");
        reg_rd(`BAI_REG_STATUS, 8'h18, "sub borrow");
        // Rotates through carry
        exec(fop(`BAI_OPC_ROTL, 1'b1, 6));
        chk("rotl file", mdl.mem[6], 8'h86);
        reg_rd(`BAI_REG_STATUS, 8'h19, "rotl carry");
        exec(fop(`BAI_OPC_ROTR, 1'b0, 6));
        reg_rd(`BAI_REG_ACC, 8'hC3, "rotr acc");
        reg_rd(`BAI_REG_STATUS, 8'h18, "rotr carry");
        exec(fop(`BAI_OPC_SWAP, 1'b0, 6));
        reg_rd(`BAI_REG_ACC, 8'h68, "swap acc");
        reg_rd(`BAI_REG_STATUS, 8'h18, "swap flags");
        exec({`BAI_OPC_OPTION, 8'h00});
        reg_rd(`BAI_REG_PRESC, 8'h68, "presc");
        reg_rd(`BAI_REG_STATUS, 8'h18, "status");
        exec({`BAI_OPC_RETLIT, 8'h5A});
        chk("return cycles", 10'(cyc), 10'd2);
        chk("return pc", PC_O, 10'h155);
        reg_rd(`BAI_REG_ACC, 8'h5A, "return acc");
        reg_rd(`BAI_REG_STATUS, 8'h18, "status");
        exec({`BAI_OPC_NOP, 8'h00});
        chk("nop pc", PC_O, 10'h156);
        reg_rd(`BAI_REG_ACC, 8'h5A, "nop acc");
        reg_rd(`BAI_REG_STATUS, 8'h18, "nop flags");
        // Leave the prescaler mid-count, then power down
        ticks(600);
        reg_rd(`BAI_REG_WDT, 8'h02, "wdt count");
        reg_wr(`BAI_REG_STATUS, 8'h98);
        exec({`BAI_OPC_SLEEP, 8'h00});
        chk("sleeping", SLEEP_O, 1'b1);
        reg_rd(`BAI_REG_STATUS, 8'h90, "sleep flags");
        reg_rd(`BAI_REG_WDT, 8'h00, "sleep wdt");
        // Pin change in sleep sets the wake flag cleared by software
        reg_wr(`BAI_REG_STATUS, 8'h00);
        reg_rd(`BAI_REG_STATUS, 8'h10, "wake clear");
        @(posedge CLK_I);
        PIN_CHANGE_I <= 1'b1;
        @(posedge CLK_I);
        PIN_CHANGE_I <= 1'b0;
        reg_rd(`BAI_REG_STATUS, 8'h90, "pin wake");
        @(posedge CLK_I);
        WAKE_I <= 1'b1;
        @(posedge CLK_I);
        WAKE_I <= 1'b0;
        repeat (2) @(posedge CLK_I);
        chk("woken", INSTR_READY_O, 1'b1);
        // One tick short of a span: a cleared prescaler has not wrapped
        ticks(255);
        reg_rd(`BAI_REG_WDT, 8'h00, "wdt span");
        // Clock enable low freezes the prescaler on the brink
        @(posedge CLK_I);
        CE_I <= 1'b0;
        ticks(4);
        @(posedge CLK_I);
        CE_I <= 1'b1;
        reg_rd(`BAI_REG_WDT, 8'h00, "wdt frozen");
        ticks(1);
        reg_rd(`BAI_REG_WDT, 8'h01, "wdt after");
        stop_test();
    end
endmodule
